// >>> src/epm_power_mgr.sv
`timescale 1ns/1ns
// What this block does
// - Configuration and register contents survive both sleep states untouched.
// - States D0, D1, D2; asleep only the power control register reads.
// - Ready flag low in D1 or D2, set again once D0 resumes.
// - Any probe write while asleep returns to D0, select field to D0.
// - Select 01 enters D1; PHY, internal clock, receive wake block stay on; MAC and host bus clocks gated.
// - D1 enables frame detection; pin asserts when wake-on-LAN and pin enabled.
// - D1 frame detection sets wake status to 10b.
// - Wake interrupt flag sets on detection whatever the pin enable.
// - D2 gates MAC, host bus and internal clock; PHY energy-detect.
// - D2 carrier sets wake status 01b; pin if energy and pin enabled.
// - Carrier already present on D2 entry is detected at once.
// - Wake interrupt level holds until status or enable cleared; then W1C.
// - Pulse select one gives a 50ms pin pulse, zero a static level.
// - Pin drops when status, matching enable or pin enable is cleared.
// - PHY general power-down bit holds PHY off; clearing resets PHY.
// - Energy power-down without line energy powers PHY down.
// - Line energy powers PHY up and sets its energy interrupt flag.
// - Ready flag sets within 2ms of the wake-up probe write.
module epm_power_mgr
  import epm_pkg::*;
#(
  parameter int READY_DELAY = READY_CYCLES,
  parameter int PULSE_LEN = PULSE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire epm_bus_req_t busReq,
  output logic [DATA_W-1:0] rdData,
  input wire logic wakeFrameDet,
  input wire logic lineEnergy,
  output logic wakePin,
  output logic hostIrq,
  output logic phyIrq,
  output logic phyResetPulse,
  output epm_gates_t gates,
  output logic [1:0] powerState
);

  localparam int RDY_W = $clog2(READY_DELAY + 1);
  localparam logic [RDY_W-1:0] RDY_LOAD = RDY_W'(READY_DELAY);

  function automatic logic hit(input epm_bus_req_t req, input logic [ADDR_W-1:0] a);
    hit = (req.addr == a);
  endfunction

  epm_pstate_t pstate_ff;
  epm_pstate_t nxt_pstate;
  logic ready_ff;
  logic [RDY_W-1:0] rdyCnt_ff;
  logic readSeen_ff;
  logic pinEn_ff;
  logic pulseSel_ff;
  logic wolEn_ff;
  logic edEn_ff;
  logic [1:0] wakeStatus_ff;
  logic [1:0] nxt_wakeStatus;
  logic wakeIntSts_ff;
  logic wakeIntEn_ff;
  logic phyGpd_ff;
  logic phyEdpd_ff;
  logic phyEintFlag_ff;
  logic phyEintMask_ff;
  logic lineEnergyDly_ff;
  logic phyResetPulse_ff;
  logic [DATA_W-1:0] rdData_ff;
  logic [DATA_W-1:0] nxt_rdData;

  logic wakeWrite;
  logic regWrite;
  logic frameEvent;
  logic energyEvent;
  logic wakeLevel;
  logic [1:0] pssWrite;

  // Wake-up write needs no prior read; other writes need ready and a read
  assign wakeWrite = busReq.wr && hit(busReq, ADDR_PROBE) && (pstate_ff != PS_D0);
  assign regWrite = busReq.wr && ready_ff && readSeen_ff;
  assign pssWrite = busReq.wdata[PMT_PSS_LSB +: 2];

  assign frameEvent = (pstate_ff == PS_D1) && wakeFrameDet;
  assign energyEvent = (pstate_ff == PS_D2) && lineEnergy;

  // Internal wake interrupt level
  assign wakeLevel = ((wakeStatus_ff == WS_FRAME) && wolEn_ff) ||
                     ((wakeStatus_ff == WS_ENERGY) && edEn_ff);

  // Power state
  always_comb begin
    nxt_pstate = pstate_ff;
    unique case (pstate_ff)
      PS_D0: begin
        if (regWrite && hit(busReq, ADDR_PMT)) begin
          if (pssWrite == PSS_D1) begin
            nxt_pstate = PS_D1;
          end else if (pssWrite == PSS_D2) begin
            nxt_pstate = PS_D2;
          end
        end
      end
      PS_D1: begin
        if (wakeWrite) begin
          nxt_pstate = PS_D0;
        end
      end
      PS_D2: begin
        if (wakeWrite) begin
          nxt_pstate = PS_D0;
        end
      end
    endcase
  end

  // Sleep entry seen on the edge after the write
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pstate_ff <= PS_D0;
    end else begin
      pstate_ff <= nxt_pstate;
    end
  end

  // Ready flag and wake-up delay
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ready_ff <= 1'b1;
      rdyCnt_ff <= '0;
    end else if (nxt_pstate != PS_D0) begin
      ready_ff <= 1'b0;
      rdyCnt_ff <= '0;
    end else if (wakeWrite) begin
      ready_ff <= 1'b0;
      rdyCnt_ff <= RDY_LOAD;
    end else if (!ready_ff) begin
      if (rdyCnt_ff <= RDY_W'(1)) begin
        ready_ff <= 1'b1;
        rdyCnt_ff <= '0;
      end else begin
        rdyCnt_ff <= rdyCnt_ff - 1'b1;
      end
    end
  end

  // Write arm: a read must follow reset, sleep entry and wake
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      readSeen_ff <= 1'b0;
    end else if (busReq.rd) begin
      readSeen_ff <= 1'b1;
    end else if (wakeWrite || (nxt_pstate != pstate_ff)) begin
      readSeen_ff <= 1'b0;
    end
  end

  // Power control fields kept across sleep
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pinEn_ff <= 1'b0;
      pulseSel_ff <= 1'b0;
      wolEn_ff <= 1'b0;
      edEn_ff <= 1'b0;
    end else if (regWrite && hit(busReq, ADDR_PMT)) begin
      pinEn_ff <= busReq.wdata[PMT_PIN_EN_BIT];
      pulseSel_ff <= busReq.wdata[PMT_PULSE_BIT];
      wolEn_ff <= busReq.wdata[PMT_WOL_BIT];
      edEn_ff <= busReq.wdata[PMT_ED_BIT];
    end
  end

  // Wake status: write one clears, detection wins over clear
  always_comb begin
    nxt_wakeStatus = wakeStatus_ff;
    if (regWrite && hit(busReq, ADDR_PMT)) begin
      nxt_wakeStatus = wakeStatus_ff & ~busReq.wdata[PMT_WS_LSB +: 2];
    end
    if (frameEvent) begin
      nxt_wakeStatus = WS_FRAME;
    end else if (energyEvent) begin
      nxt_wakeStatus = WS_ENERGY;
    end
  end

  // Survives wake so software can see the cause
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wakeStatus_ff <= WS_NONE;
    end else begin
      wakeStatus_ff <= nxt_wakeStatus;
    end
  end

  // Wake interrupt status: held while level high, then write one clears
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wakeIntSts_ff <= 1'b0;
    end else if (wakeLevel) begin
      wakeIntSts_ff <= 1'b1;
    end else if (regWrite && hit(busReq, ADDR_IRQ_STS) && busReq.wdata[INT_WAKE_BIT]) begin
      wakeIntSts_ff <= 1'b0;
    end
  end

  // Enable masks the host line only; status still sets
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wakeIntEn_ff <= 1'b0;
    end else if (regWrite && hit(busReq, ADDR_INT_EN)) begin
      wakeIntEn_ff <= busReq.wdata[INT_WAKE_BIT];
    end
  end

  assign hostIrq = wakeIntSts_ff & wakeIntEn_ff;

  // PHY control bits
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      phyGpd_ff <= 1'b0;
      phyResetPulse_ff <= 1'b0;
    end else begin
      phyResetPulse_ff <= 1'b0;
      if (regWrite && hit(busReq, ADDR_PHY_CTRL)) begin
        phyGpd_ff <= busReq.wdata[PHY_GPD_BIT];
        phyResetPulse_ff <= phyGpd_ff && !busReq.wdata[PHY_GPD_BIT];
      end
    end
  end

  // Energy power-down is host owned; not cleared on wake
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      phyEdpd_ff <= 1'b0;
      phyEintMask_ff <= 1'b0;
    end else begin
      if (regWrite && hit(busReq, ADDR_PHY_MODE)) begin
        phyEdpd_ff <= busReq.wdata[PHY_EDPD_BIT];
      end
      if (regWrite && hit(busReq, ADDR_PHY_IMASK)) begin
        phyEintMask_ff <= busReq.wdata[PHY_EINT_BIT];
      end
    end
  end

  // PHY energy interrupt flag: rising line energy in energy-detect mode
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lineEnergyDly_ff <= 1'b0;
      phyEintFlag_ff <= 1'b0;
    end else begin
      lineEnergyDly_ff <= lineEnergy;
      if (phyEdpd_ff && lineEnergy && !lineEnergyDly_ff) begin
        phyEintFlag_ff <= 1'b1;
      end else if (regWrite && hit(busReq, ADDR_PHY_ISRC) && busReq.wdata[PHY_EINT_BIT]) begin
        phyEintFlag_ff <= 1'b0;
      end
    end
  end

  assign phyIrq = phyEintFlag_ff & phyEintMask_ff;

  // Clock and power gating per state
  always_comb begin
    gates.phyOn = !phyGpd_ff && !(phyEdpd_ff && !lineEnergy);
    gates.phyEdForce = (pstate_ff == PS_D2);
    gates.rxPmClkEn = (pstate_ff != PS_D2);
    gates.macClkEn = (pstate_ff == PS_D0);
    gates.hostIfClkEn = (pstate_ff == PS_D0);
    gates.intClkEn = (pstate_ff != PS_D2);
  end

  // Read path: asleep or not ready only power control answers
  always_comb begin
    nxt_rdData = READ_UNDEF;
    if (busReq.rd) begin
      if (hit(busReq, ADDR_PMT)) begin
        nxt_rdData[PMT_READY_BIT] = ready_ff;
        nxt_rdData[PMT_PIN_EN_BIT] = pinEn_ff;
        nxt_rdData[PMT_PULSE_BIT] = pulseSel_ff;
        nxt_rdData[PMT_WS_LSB +: 2] = wakeStatus_ff;
        nxt_rdData[PMT_WOL_BIT] = wolEn_ff;
        nxt_rdData[PMT_PSS_LSB +: 2] = powerState;
        nxt_rdData[PMT_ED_BIT] = edEn_ff;
      end else if (ready_ff) begin
        if (hit(busReq, ADDR_PROBE)) begin
          nxt_rdData = PROBE_PATTERN;
        end else if (hit(busReq, ADDR_IRQ_STS)) begin
          nxt_rdData[INT_WAKE_BIT] = wakeIntSts_ff;
        end else if (hit(busReq, ADDR_INT_EN)) begin
          nxt_rdData[INT_WAKE_BIT] = wakeIntEn_ff;
        end else if (hit(busReq, ADDR_PHY_CTRL)) begin
          nxt_rdData[PHY_GPD_BIT] = phyGpd_ff;
        end else if (hit(busReq, ADDR_PHY_MODE)) begin
          nxt_rdData[PHY_EDPD_BIT] = phyEdpd_ff;
        end else if (hit(busReq, ADDR_PHY_ISRC)) begin
          nxt_rdData[PHY_EINT_BIT] = phyEintFlag_ff;
        end else if (hit(busReq, ADDR_PHY_IMASK)) begin
          nxt_rdData[PHY_EINT_BIT] = phyEintMask_ff;
        end
      end
    end
  end

  // Read data stands one cycle, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdData_ff <= '0;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  assign rdData = rdData_ff;
  assign phyResetPulse = phyResetPulse_ff;

  // Select field reads back the live state
  always_comb begin
    powerState = PSS_D0;
    unique case (pstate_ff)
      PS_D0: powerState = PSS_D0;
      PS_D1: powerState = PSS_D1;
      PS_D2: powerState = PSS_D2;
    endcase
  end

  // Pin follows the internal level only while pin enabled
  epm_wake_pin #(
    .PULSE_LEN(PULSE_LEN)
  ) u_wake_pin (
    .clk_sys(clk_sys),
    .reset(reset),
    .wakeActive(wakeLevel && pinEn_ff),
    .pulseSel(pulseSel_ff),
    .wakePin(wakePin)
  );

endmodule

// >>> inc/epm_pkg.sv
package epm_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STS = 8'h58;
  localparam logic [ADDR_W-1:0] ADDR_INT_EN = 8'h5C;
  localparam logic [ADDR_W-1:0] ADDR_PROBE = 8'h64;
  localparam logic [ADDR_W-1:0] ADDR_PMT = 8'h84;
  localparam logic [ADDR_W-1:0] ADDR_PHY_CTRL = 8'hA0;
  localparam logic [ADDR_W-1:0] ADDR_PHY_MODE = 8'hA4;
  localparam logic [ADDR_W-1:0] ADDR_PHY_ISRC = 8'hA8;
  localparam logic [ADDR_W-1:0] ADDR_PHY_IMASK = 8'hAC;

  // power_mgmt_ctrl_reg fields
  localparam int PMT_READY_BIT = 0;
  localparam int PMT_PIN_EN_BIT = 1;
  localparam int PMT_PULSE_BIT = 3;
  localparam int PMT_WS_LSB = 4;
  localparam int PMT_WOL_BIT = 9;
  localparam int PMT_PSS_LSB = 12;
  localparam int PMT_ED_BIT = 14;

  // interrupt_status_reg / enable field
  localparam int INT_WAKE_BIT = 17;

  // PHY register fields
  localparam int PHY_GPD_BIT = 11;
  localparam int PHY_EDPD_BIT = 13;
  localparam int PHY_EINT_BIT = 1;

  // power_state_select and wake_status_field encodings
  localparam logic [1:0] PSS_D0 = 2'h0;
  localparam logic [1:0] PSS_D1 = 2'h1;
  localparam logic [1:0] PSS_D2 = 2'h2;
  localparam logic [1:0] WS_NONE = 2'h0;
  localparam logic [1:0] WS_ENERGY = 2'h1;
  localparam logic [1:0] WS_FRAME = 2'h2;

  // Probe register read pattern; value arbitrary
  localparam logic [DATA_W-1:0] PROBE_PATTERN = 32'h13579BDF;
  localparam logic [DATA_W-1:0] READ_UNDEF = 32'h00000000;

  // Timing
  localparam int CLK_HZ = 50000000;
  localparam int READY_TIME_US = 2000;
  localparam int PULSE_TIME_US = 50000;
  localparam int READY_CYCLES = READY_TIME_US * (CLK_HZ / 1000000);
  localparam int PULSE_CYCLES = PULSE_TIME_US * (CLK_HZ / 1000000);

  typedef enum logic [1:0] {PS_D0, PS_D1, PS_D2} epm_pstate_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } epm_bus_req_t;

  typedef struct packed {
    logic phyOn;
    logic phyEdForce;
    logic rxPmClkEn;
    logic macClkEn;
    logic hostIfClkEn;
    logic intClkEn;
  } epm_gates_t;

endpackage

// >>> src/epm_wake_pin.sv
`timescale 1ns/1ns
module epm_wake_pin
  import epm_pkg::*;
#(
  parameter int PULSE_LEN = PULSE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic wakeActive,
  input wire logic pulseSel,
  output logic wakePin
);

  localparam int CNT_W = $clog2(PULSE_LEN + 1);
  localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_LEN);

  logic activeDly_ff;
  logic [CNT_W-1:0] pulseCnt_ff;
  logic [CNT_W-1:0] nxt_pulseCnt;
  logic wakePin_ff;
  logic nxt_wakePin;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      activeDly_ff <= 1'b0;
    end else begin
      activeDly_ff <= wakeActive;
    end
  end

  // Pulse timer loads on each new wake event
  always_comb begin
    nxt_pulseCnt = pulseCnt_ff;
    if (!wakeActive) begin
      nxt_pulseCnt = '0;
    end else if (!activeDly_ff) begin
      nxt_pulseCnt = PULSE_LOAD;
    end else if (pulseCnt_ff != '0) begin
      nxt_pulseCnt = pulseCnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pulseCnt_ff <= '0;
    end else begin
      pulseCnt_ff <= nxt_pulseCnt;
    end
  end

  always_comb begin
    nxt_wakePin = wakeActive & (!pulseSel | (nxt_pulseCnt != '0));
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wakePin_ff <= 1'b0;
    end else begin
      wakePin_ff <= nxt_wakePin;
    end
  end

  assign wakePin = wakePin_ff;

endmodule

// >>> tb/epm_host_model.sv
`timescale 1ns/1ns
module epm_host_model
  import epm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [DATA_W-1:0] rdData,
  output epm_bus_req_t busReq
);
  initial busReq = '0;
  // Write data turned over once released; strobes never overlap
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    busReq.wr <= 1'b0;
    busReq.wdata <= ~d;
  endtask
  // Reads always allowed; a read arms later writes
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: busReq.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    busReq.rd <= 1'b0;
    #1 d = rdData;
  endtask
endmodule

// >>> tb/epm_power_mgr_asserts.sv
`timescale 1ns/1ns
module epm_power_mgr_asserts
  import epm_pkg::*;
#(
  parameter int READY_DELAY = READY_CYCLES,
  parameter int PULSE_LEN = PULSE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire epm_bus_req_t busReq,
  input wire logic [DATA_W-1:0] rdData,
  input wire logic phyResetPulse,
  input wire epm_gates_t gates,
  input wire logic [1:0] powerState
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic asleep;
  assign asleep = powerState != PSS_D0;
  sequence s_enter;
    powerState == PSS_D0 ##1 asleep;
  endsequence
  property p_rdIdle;
    !$past(busReq.rd) |-> rdData == '0;
  endproperty
  property p_d1Gates;
    powerState == PSS_D1 |-> gates.phyOn && gates.rxPmClkEn && gates.intClkEn
      && !gates.macClkEn && !gates.hostIfClkEn;
  endproperty
  property p_d2Gates;
    powerState == PSS_D2 |->
      !(gates.macClkEn | gates.hostIfClkEn | gates.intClkEn | gates.rxPmClkEn);
  endproperty
  property p_wake;
    asleep && busReq.wr && busReq.addr == ADDR_PROBE |=> powerState == PSS_D0;
  endproperty
  property p_readyLow;
    asleep && busReq.rd && busReq.addr == ADDR_PMT |=> !rdData[PMT_READY_BIT];
  endproperty
  property p_sleepRd;
    asleep && busReq.rd && busReq.addr != ADDR_PMT |=> rdData == READ_UNDEF;
  endproperty
  property p_phyRst;
    phyResetPulse |-> $past(busReq.wr) && $past(busReq.addr) == ADDR_PHY_CTRL
      ##1 !phyResetPulse;
  endproperty
  property p_enter;
    s_enter |-> $past(busReq.wr) && $past(busReq.addr) == ADDR_PMT;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data without read");
  a_d1Gates: assert property (p_d1Gates) else $error("D1 gating wrong");
  a_d2Gates: assert property (p_d2Gates) else $error("D2 gating wrong");
  a_wake: assert property (p_wake) else $error("probe write did not wake");
  a_readyLow: assert property (p_readyLow) else $error("ready set asleep");
  a_sleepRd: assert property (p_sleepRd) else $error("data read asleep");
  a_phyRst: assert property (p_phyRst) else $error("bad PHY reset pulse");
  a_enter: assert property (p_enter) else $error("sleep without write");
endmodule
bind epm_power_mgr epm_power_mgr_asserts #(.READY_DELAY(READY_DELAY), .PULSE_LEN(PULSE_LEN))
  u_chk (.clk_sys(clk_sys), .reset(reset), .busReq(busReq), .rdData(rdData),
  .phyResetPulse(phyResetPulse), .gates(gates), .powerState(powerState));

// >>> tb/epm_power_mgr_tb_top.sv
`timescale 1ns/1ns
module epm_power_mgr_tb_top
  import epm_pkg::*;
;
  localparam int RD = 5;
  localparam int PL = 8;
  localparam logic [31:0] PIN = 32'h1 << PMT_PIN_EN_BIT;
  localparam logic [31:0] PUL = 32'h1 << PMT_PULSE_BIT;
  localparam logic [31:0] WOL = 32'h1 << PMT_WOL_BIT;
  localparam logic [31:0] EDE = 32'h1 << PMT_ED_BIT;
  localparam logic [31:0] WIB = 32'h1 << INT_WAKE_BIT;
  logic clk_sys, reset, wakeFrameDet, lineEnergy;
  logic wakePin, hostIrq, phyIrq, phyResetPulse;
  logic [1:0] powerState;
  logic [DATA_W-1:0] rdData, d;
  epm_bus_req_t busReq;
  epm_gates_t gates;
  int fail_count, checked;
  epm_host_model host (.clk_sys(clk_sys), .rdData(rdData), .busReq(busReq));
  epm_power_mgr #(.READY_DELAY(RD), .PULSE_LEN(PL)) dut (.clk_sys(clk_sys), .reset(reset),
    .busReq(busReq), .rdData(rdData), .wakeFrameDet(wakeFrameDet), .lineEnergy(lineEnergy),
    .wakePin(wakePin), .hostIrq(hostIrq), .phyIrq(phyIrq), .phyResetPulse(phyResetPulse),
    .gates(gates), .powerState(powerState));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic stop_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic waitPin();
    int n;
    n = 0;
    while (wakePin !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > 20) begin
        fail_count++;
        stop_test();
      end
    end
  endtask
  task automatic waitReady();
    int n;
    n = 0;
    d = 32'h0;
    while (d[PMT_READY_BIT] !== 1'b1) begin
      host.rd(ADDR_PMT, d);
      n++;
      if (n > RD) begin
        fail_count++;
        stop_test();
      end
    end
  endtask
  initial begin
    int n;
    reset = 1'b1;
    wakeFrameDet = 1'b0;
    lineEnergy = 1'b0;
    fail_count = 0;
    checked = 0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    host.wr(ADDR_PMT, PIN);
    host.rd(ADDR_PMT, d);
    chk(d, 32'h1);
    host.rd(ADDR_PROBE, d);
    chk(d, PROBE_PATTERN);
    host.rd(8'hF0, d);
    chk(d, READ_UNDEF);
    // Frame wake from D1, pulsed pin
    host.wr(ADDR_INT_EN, WIB);
    host.wr(ADDR_PMT, PIN | PUL | WOL | (32'(PSS_D1) << PMT_PSS_LSB));
    #1 chk(powerState, PSS_D1);
    chk(gates.macClkEn, 1'b0);
    chk(gates.phyEdForce, 1'b0);
    host.rd(ADDR_PMT, d);
    chk(d, PIN | PUL | WOL | (32'(PSS_D1) << PMT_PSS_LSB));
    host.wr(ADDR_INT_EN, 32'h0);
    host.rd(ADDR_INT_EN, d);
    chk(d, READ_UNDEF);
    @(posedge clk_sys);
    wakeFrameDet <= 1'b1;
    @(posedge clk_sys);
    wakeFrameDet <= 1'b0;
    waitPin();
    n = 0;
    while (wakePin === 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(n, PL);
    chk(hostIrq, 1'b1);
    host.wr(ADDR_PROBE, 32'h0);
    #1 chk(powerState, PSS_D0);
    waitReady();
    chk(d, 32'h1 | PIN | PUL | WOL | (32'(WS_FRAME) << PMT_WS_LSB));
    host.wr(ADDR_IRQ_STS, WIB);
    #1 chk(hostIrq, 1'b1);
    host.wr(ADDR_PMT, PIN | PUL | WOL | (32'h3 << PMT_WS_LSB));
    host.wr(ADDR_IRQ_STS, WIB);
    #1 chk(hostIrq, 1'b0);
    // Energy wake from D2, carrier present at entry, static pin
    host.wr(ADDR_PHY_MODE, 32'h1 << PHY_EDPD_BIT);
    lineEnergy <= 1'b1;
    host.wr(ADDR_PMT, PIN | EDE | (32'(PSS_D2) << PMT_PSS_LSB));
    #1 chk(powerState, PSS_D2);
    chk(gates.intClkEn, 1'b0);
    chk(gates.phyEdForce, 1'b1);
    waitPin();
    repeat (12) @(posedge clk_sys);
    #1 chk(wakePin, 1'b1);
    host.rd(ADDR_PMT, d);
    chk(d, PIN | EDE | (32'(PSS_D2) << PMT_PSS_LSB) | (32'(WS_ENERGY) << PMT_WS_LSB));
    host.wr(ADDR_PROBE, 32'h0);
    waitReady();
    host.wr(ADDR_PMT, EDE);
    lineEnergy <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk(wakePin, 1'b0);
    chk(hostIrq, 1'b1);
    host.wr(ADDR_PHY_MODE, 32'h0);
    // PHY power-down modes
    host.wr(ADDR_PHY_CTRL, 32'h1 << PHY_GPD_BIT);
    #1 chk(gates.phyOn, 1'b0);
    host.wr(ADDR_PHY_CTRL, 32'h0);
    #1 chk(phyResetPulse, 1'b1);
    host.wr(ADDR_PHY_IMASK, 32'h1 << PHY_EINT_BIT);
    host.wr(ADDR_PHY_MODE, 32'h1 << PHY_EDPD_BIT);
    host.wr(ADDR_PHY_ISRC, 32'h1 << PHY_EINT_BIT);
    #1 chk(gates.phyOn, 1'b0);
    chk(phyIrq, 1'b0);
    @(posedge clk_sys);
    lineEnergy <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk(gates.phyOn, 1'b1);
    chk(phyIrq, 1'b1);
    stop_test();
  end
endmodule
